// >>> rtl/odt_defines.svh
`ifndef ODT_DEFINES_SVH
`define ODT_DEFINES_SVH

// register byte offsets
`define MODE1_OFS   12'h000
`define MODE2_OFS   12'h004
`define LAT_OFS     12'h008
`define STAT_OFS    12'h00c

// mode and latency register field positions
`define MR1_B2      2
`define MR1_B6      6
`define MR1_B9      9
`define MR2_B9      9
`define MR2_B10     10
`define LAT_CWL_LSB 0
`define LAT_AL_LSB  8
`define LAT_FLD_W   5

// status bit positions
`define ST_PEND     0
`define ST_RTT_ON   1
`define ST_WR_SEL   2
`define ST_NOM_RSVD 3
`define ST_WR_RSVD  4
`define ST_LAT_ERR  5

// reset values
`define NOM_RST     3'h0
`define WRC_RST     2'h0
`define CWL_RST     5'h05
`define AL_RST      5'h00

// timing counts, in cycles of the link clock
`define ODTL_SUB    2
`define CWN4_CYC    4
`define CWN8_CYC    6
`define ODTH4_CYC   4
`define ODTH8_CYC   6
`define TADC_CYC    1

`endif

// >>> rtl/odt_pkg.sv
package odt_pkg;

    typedef enum logic [2:0] {
        RTT_OFF,
        RTT_RZQ4,
        RTT_RZQ2,
        RTT_RZQ6,
        RTT_RZQ12,
        RTT_RZQ8,
        RTT_RSVD
    } rtt_e;

    typedef enum logic [1:0] {
        WR_IDLE,
        WR_WAIT,
        WR_ACTIVE
    } wr_state_e;

endpackage

// >>> rtl/odt_sync.sv
`timescale 1ns/1ns
module odt_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // the first stage feeds the second stage only
    always_comb begin
        meta_d = d;
        sync_d = meta_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q = sync_q;
endmodule

// >>> rtl/dynamic_odt_control.sv
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "odt_defines.svh"
module dynamic_odt_control
    import odt_pkg::*;
#(
    parameter int ODTL_MAX = 16
) (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ck,
    input  wire logic        odt,
    input  wire logic        wr_cmd,
    input  wire logic        wr_bc4,
    output rtt_e             rtt_value,
    output logic             rtt_wr_sel,
    output logic             rtt_settle
);
    localparam int LW = $clog2(ODTL_MAX + 1);
    localparam int CW = $clog2(ODTL_MAX + `CWN8_CYC + 2);

    if (ODTL_MAX < 1 || ODTL_MAX > 60) begin : g_bad_odtl
        $error("ODTL_MAX must lie between 1 and 60");
    end

    function automatic rtt_e nom_decode(input logic [2:0] c);
        rtt_e r;
        unique case (c)
            3'h0: r = RTT_OFF;
            3'h1: r = RTT_RZQ4;
            3'h2: r = RTT_RZQ2;
            3'h3: r = RTT_RZQ6;
            3'h4: r = RTT_RZQ12;
            3'h5: r = RTT_RZQ8;
            default: r = RTT_RSVD;
        endcase
        return r;
    endfunction

    function automatic rtt_e wr_decode(input logic [1:0] c);
        rtt_e r;
        unique case (c)
            2'h0: r = RTT_OFF;
            2'h1: r = RTT_RZQ4;
            2'h2: r = RTT_RZQ2;
            2'h3: r = RTT_RSVD;
        endcase
        return r;
    endfunction

    logic          rst_n;
    logic          lrst_n;
    logic          ack_s;
    logic          req_s;
    logic [1:0]    stat_s;

    // register side
    logic [2:0]    nom_q,    nom_d;
    logic [1:0]    wrc_q,    wrc_d;
    logic [4:0]    cwl_q,    cwl_d;
    logic [4:0]    al_q,     al_d;
    logic          req_q,    req_d;
    logic [31:0]   prdata_q, prdata_d;
    logic          perr_q,   perr_d;
    logic [5:0]    wl;
    logic [5:0]    odtl_full;
    logic          lat_err;
    logic [LW-1:0] odtl_send;
    logic          pend;
    logic [31:0]   rd;
    logic          err;
    logic          cfg_addr;

    // link side
    logic [ODTL_MAX:0] hist_q, hist_d;
    logic [2:0]        lnom_q, lnom_d;
    logic [1:0]        lwrc_q, lwrc_d;
    logic [LW-1:0]     lodtl_q, lodtl_d;
    logic              ack_q, ack_d;
    wr_state_e         st_q, st_d;
    logic [CW-1:0]     cnt_q, cnt_d;
    logic              bc4_q, bc4_d;
    rtt_e              val_q, val_d;
    logic              rtt_on_q, rtt_on_d;
    logic              wr_sel_q, wr_sel_d;
    logic              settle_q, settle_d;
    logic              dyn_en;
    logic [CW-1:0]     cnw;
    logic [CW-1:0]     cwn;

    odt_sync #(.W(1)) u_rst_ref (
        .clk    (ref_clk),
        .arst_n (arst_n),
        .d      (1'b1),
        .q      (rst_n)
    );

    odt_sync #(.W(1)) u_rst_ck (
        .clk    (ck),
        .arst_n (arst_n),
        .d      (1'b1),
        .q      (lrst_n)
    );

    odt_sync #(.W(1)) u_ack_sync (
        .clk    (ref_clk),
        .arst_n (rst_n),
        .d      (ack_q),
        .q      (ack_s)
    );

    odt_sync #(.W(1)) u_req_sync (
        .clk    (ck),
        .arst_n (lrst_n),
        .d      (req_q),
        .q      (req_s)
    );

    odt_sync #(.W(2)) u_stat_sync (
        .clk    (ref_clk),
        .arst_n (rst_n),
        .d      ({wr_sel_q, rtt_on_q}),
        .q      (stat_s)
    );

    // latencies derived once here so the link side only copies a number
    always_comb begin
        wl        = {1'b0, cwl_q} + {1'b0, al_q};
        odtl_full = (wl >= 6'(`ODTL_SUB)) ? wl - 6'(`ODTL_SUB) : 6'h00;
        lat_err   = odtl_full > 6'(ODTL_MAX);
        odtl_send = lat_err ? LW'(ODTL_MAX) : odtl_full[LW-1:0];
    end

    assign pend     = req_q ^ ack_s;
    assign pready   = 1'b1;
    assign cfg_addr = (paddr == `MODE1_OFS) || (paddr == `MODE2_OFS) ||
                      (paddr == `LAT_OFS);

    always_comb begin
        rd  = 32'h0000_0000;
        err = 1'b0;
        unique case (paddr)
            `MODE1_OFS: begin
                rd[`MR1_B9] = nom_q[2];
                rd[`MR1_B6] = nom_q[1];
                rd[`MR1_B2] = nom_q[0];
            end
            `MODE2_OFS: begin
                rd[`MR2_B10] = wrc_q[1];
                rd[`MR2_B9]  = wrc_q[0];
            end
            `LAT_OFS: begin
                rd[`LAT_CWL_LSB +: `LAT_FLD_W] = cwl_q;
                rd[`LAT_AL_LSB +: `LAT_FLD_W]  = al_q;
            end
            `STAT_OFS: begin
                rd[`ST_PEND]     = pend;
                rd[`ST_RTT_ON]   = stat_s[0];
                rd[`ST_WR_SEL]   = stat_s[1];
                rd[`ST_NOM_RSVD] = nom_q[2] & nom_q[1];
                rd[`ST_WR_RSVD]  = &wrc_q;
                rd[`ST_LAT_ERR]  = lat_err;
            end
            default: err = 1'b1;
        endcase
        // the link copies the fields without a second handshake, so they
        // must not move while a copy is in flight
        if (pwrite && cfg_addr && pend) begin
            err = 1'b1;
        end
    end

    always_comb begin
        nom_d    = nom_q;
        wrc_d    = wrc_q;
        cwl_d    = cwl_q;
        al_d     = al_q;
        req_d    = req_q;
        prdata_d = prdata_q;
        perr_d   = 1'b0;
        if (psel && !penable) begin
            prdata_d = pwrite ? 32'h0000_0000 : rd;
            perr_d   = err;
        end else if (psel && penable) begin
            perr_d = perr_q;
            if (pwrite && !perr_q && cfg_addr) begin
                req_d = ~req_q;
                unique case (paddr)
                    `MODE1_OFS: nom_d = {pwdata[`MR1_B9], pwdata[`MR1_B6],
                                         pwdata[`MR1_B2]};
                    `MODE2_OFS: wrc_d = {pwdata[`MR2_B10], pwdata[`MR2_B9]};
                    default: begin
                        cwl_d = pwdata[`LAT_CWL_LSB +: `LAT_FLD_W];
                        al_d  = pwdata[`LAT_AL_LSB +: `LAT_FLD_W];
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            nom_q    <= `NOM_RST;
            wrc_q    <= `WRC_RST;
            cwl_q    <= `CWL_RST;
            al_q     <= `AL_RST;
            req_q    <= 1'b0;
            prdata_q <= 32'h0000_0000;
            perr_q   <= 1'b0;
        end else begin
            nom_q    <= nom_d;
            wrc_q    <= wrc_d;
            cwl_q    <= cwl_d;
            al_q     <= al_d;
            req_q    <= req_d;
            prdata_q <= prdata_d;
            perr_q   <= perr_d;
        end
    end

    assign prdata  = prdata_q;
    assign pslverr = perr_q;

    // link clock domain
    always_comb begin
        lnom_d  = lnom_q;
        lwrc_d  = lwrc_q;
        lodtl_d = lodtl_q;
        ack_d   = ack_q;
        if (req_s != ack_q) begin
            lnom_d  = nom_q;
            lwrc_d  = wrc_q;
            lodtl_d = odtl_send;
            ack_d   = req_s;
        end
        dyn_en = |lwrc_d;
        hist_d = {hist_q[ODTL_MAX-1:0], odt};
        cnw    = CW'(lodtl_q);
        cwn    = CW'(lodtl_q) + (bc4_q ? CW'(`CWN4_CYC) : CW'(`CWN8_CYC));
        st_d   = st_q;
        bc4_d  = bc4_q;
        cnt_d  = (cnt_q != '1) ? cnt_q + CW'(1) : cnt_q;
        unique case (st_q)
            WR_IDLE: ;
            WR_WAIT: if (cnt_q == cnw) begin
                st_d = WR_ACTIVE;
            end
            WR_ACTIVE: if (cnt_q == cwn) begin
                st_d = WR_IDLE;
            end
        endcase
        // a write in the closing cycle keeps write termination on
        if (wr_cmd && |lwrc_q) begin
            cnt_d = CW'(1);
            bc4_d = wr_bc4;
            if (st_q == WR_ACTIVE || lodtl_q == '0) begin
                st_d = WR_ACTIVE;
            end else begin
                st_d = WR_WAIT;
            end
        end
        if (!dyn_en) begin
            st_d = WR_IDLE;
        end
        rtt_on_d = hist_d[lodtl_q];
        wr_sel_d = (st_d == WR_ACTIVE);
        if (!rtt_on_d) begin
            val_d = RTT_OFF;
        end else if (wr_sel_d) begin
            val_d = wr_decode(lwrc_d);
        end else begin
            val_d = nom_decode(lnom_d);
        end
        settle_d = rtt_on_d && (wr_sel_d != wr_sel_q);
    end

    always_ff @(posedge ck or negedge lrst_n) begin
        if (!lrst_n) begin
            hist_q   <= '0;
            lnom_q   <= `NOM_RST;
            lwrc_q   <= `WRC_RST;
            lodtl_q  <= '0;
            ack_q    <= 1'b0;
            st_q     <= WR_IDLE;
            cnt_q    <= '0;
            bc4_q    <= 1'b0;
            val_q    <= RTT_OFF;
            rtt_on_q <= 1'b0;
            wr_sel_q <= 1'b0;
            settle_q <= 1'b0;
        end else begin
            hist_q   <= hist_d;
            lnom_q   <= lnom_d;
            lwrc_q   <= lwrc_d;
            lodtl_q  <= lodtl_d;
            ack_q    <= ack_d;
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            bc4_q    <= bc4_d;
            val_q    <= val_d;
            rtt_on_q <= rtt_on_d;
            wr_sel_q <= wr_sel_d;
            settle_q <= settle_d;
        end
    end

    assign rtt_value  = val_q;
    assign rtt_wr_sel = wr_sel_q;
    assign rtt_settle = settle_q;

    dyn_enable_a: assert property (@(posedge ck) disable iff (!lrst_n)
        wr_sel_q |-> |lwrc_q)
        else $error("write termination without dynamic enable");
    nom_decode_a: assert property (@(posedge ck) disable iff (!lrst_n)
        rtt_on_q && !wr_sel_q && lnom_q == 3'h4 |-> rtt_value == RTT_RZQ12)
        else $error("nominal code 100 not decoded as RZQ/12");
    wr_decode_a: assert property (@(posedge ck) disable iff (!lrst_n)
        rtt_on_q && wr_sel_q |->
        rtt_value == (lwrc_q == 2'h1 ? RTT_RZQ4 :
                      lwrc_q == 2'h2 ? RTT_RZQ2 : RTT_RSVD))
        else $error("write termination value wrong");
    odt_off_a: assert property (@(posedge ck) disable iff (!lrst_n)
        !rtt_on_q |-> rtt_value == RTT_OFF)
        else $error("termination on while odt path off");
    on_latency_a: assert property (@(posedge ck) disable iff (!lrst_n)
        lodtl_q == 4 && $past(lodtl_q, 5) == 4 && $past(lrst_n, 6) |->
        rtt_on_q == $past(odt, 5))
        else $error("odt latency not write latency minus two");
    cnw_switch_a: assert property (@(posedge ck) disable iff (!lrst_n)
        $rose(wr_sel_q) |-> cnt_q == CW'(lodtl_q) + CW'(1))
        else $error("switch to write termination at wrong cycle");
    bl8_return_a: assert property (@(posedge ck) disable iff (!lrst_n)
        $fell(wr_sel_q) && |lwrc_q && !bc4_q |->
        cnt_q == CW'(lodtl_q) + CW'(`CWN8_CYC + 1))
        else $error("eight-beat return to nominal at wrong cycle");
    bc4_return_a: assert property (@(posedge ck) disable iff (!lrst_n)
        $fell(wr_sel_q) && |lwrc_q && bc4_q |->
        cnt_q == CW'(lodtl_q) + CW'(`CWN4_CYC + 1))
        else $error("chopped return to nominal at wrong cycle");
    restart_wr_a: assert property (@(posedge ck) disable iff (!lrst_n)
        wr_cmd && wr_sel_q && |lwrc_q && $stable(lwrc_q) |=>
        wr_sel_q && cnt_q == CW'(1) && bc4_q == $past(wr_bc4))
        else $error("newer write did not restart the countdown");
    settle_win_a: assert property (@(posedge ck) disable iff (!lrst_n)
        $rose(wr_sel_q) && rtt_on_q |-> rtt_settle ##1 !rtt_settle)
        else $error("settle window not one cycle at the switch");

    bl8_done_c: cover property (@(posedge ck) disable iff (!lrst_n)
        $fell(wr_sel_q) && !bc4_q);
    bc4_done_c: cover property (@(posedge ck) disable iff (!lrst_n)
        $fell(wr_sel_q) && bc4_q);
    restart_c: cover property (@(posedge ck) disable iff (!lrst_n)
        wr_cmd && wr_sel_q);
    wr_term_on_c: cover property (@(posedge ck) disable iff (!lrst_n)
        rtt_on_q && wr_sel_q);
endmodule

// >>> verification/odt_ctrl_model.sv
`timescale 1ns/1ns
module odt_ctrl_model (
    input  wire logic ck,
    output logic      odt,
    output logic      wr_cmd,
    output logic      wr_bc4
);
    initial begin
        odt    = 1'b0;
        wr_cmd = 1'b0;
        wr_bc4 = 1'b1;
    end

    // odt is registered high at the first edge for hold edges; writes at
    // edge 0 and at edge gap (gap 0 means a single write)
    task automatic burst(input logic wr, input logic bc4, input int hold,
                         input int gap);
        int n;
        int i;
        logic w;
        n = wr ? gap + (bc4 ? 4 : 6) : 4;
        if (hold < n) begin
            hold = n;
        end
        for (i = 0; i <= hold; i++) begin
            @(posedge ck);
            w = wr && (i == 0 || i == gap);
            odt    <= (i < hold);
            wr_cmd <= w;
            // the chop flag outside a write flips so no stale value helps
            wr_bc4 <= w ? bc4 : ~wr_bc4;
        end
    endtask
endmodule

// >>> verification/tb_dynamic_odt_control.sv
`timescale 1ns/1ns
`include "odt_defines.svh"
module tb_dynamic_odt_control;
    import odt_pkg::*;
    logic        ref_clk;
    logic        ck;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        odt;
    logic        wr_cmd;
    logic        wr_bc4;
    rtt_e        rtt_value;
    logic        rtt_wr_sel;
    logic        rtt_settle;
    logic [31:0] rd;
    logic        err;
    int          num_errors;
    int          cmp_count;
    int          lat_l;
    int          c;

    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;
    initial ck = 1'b0;
    always #15 ck = ~ck;

    dynamic_odt_control dut (
        .ref_clk    (ref_clk),
        .arst_n     (arst_n),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .ck         (ck),
        .odt        (odt),
        .wr_cmd     (wr_cmd),
        .wr_bc4     (wr_bc4),
        .rtt_value  (rtt_value),
        .rtt_wr_sel (rtt_wr_sel),
        .rtt_settle (rtt_settle)
    );

    odt_ctrl_model ctl (
        .ck     (ck),
        .odt    (odt),
        .wr_cmd (wr_cmd),
        .wr_bc4 (wr_bc4)
    );

    task automatic summarize;
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_rtt(input string nm, input rtt_e exp, input rtt_e got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // a new config write is refused until the copy to the link is done
    task automatic cfg(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("cfg_err", 32'h0, 32'(err));
        do apb(1'b0, `STAT_OFS, 32'h0); while (rd[`ST_PEND] !== 1'b0);
    endtask

    function automatic logic [31:0] mr1(input logic [2:0] v);
        mr1 = (32'(v[2]) << `MR1_B9) | (32'(v[1]) << `MR1_B6)
            | (32'(v[0]) << `MR1_B2);
    endfunction

    function automatic logic [31:0] mr2(input logic [1:0] v);
        mr2 = (32'(v[1]) << `MR2_B10) | (32'(v[0]) << `MR2_B9);
    endfunction

    function automatic rtt_e nom_of(input logic [2:0] v);
        nom_of = rtt_e'(v > 3'h5 ? 3'h6 : v);
    endfunction

    function automatic rtt_e wr_of(input logic [1:0] v);
        wr_of = v == 2'h1 ? RTT_RZQ4 : v == 2'h2 ? RTT_RZQ2
              : v == 2'h3 ? RTT_RSVD : RTT_OFF;
    endfunction

    // k counts link edges after the one that registers odt and the write
    task automatic run(input logic wr, input logic dyn, input logic bc4,
                       input int hold, input int gap, input rtt_e nv,
                       input rtt_e wv);
        int   k;
        int   last;
        logic on;
        logic sel;
        logic was;
        last = gap + lat_l + (bc4 ? 4 : 6);
        was  = 1'b0;
        fork
            ctl.burst(wr, bc4, hold, gap);
            begin
                repeat (2) @(posedge ck);
                for (k = 0; k <= hold + lat_l + 8; k++) begin
                    #1;
                    on  = k >= lat_l && k - lat_l < hold;
                    sel = wr && dyn && k >= lat_l && k < last;
                    chk("wr_sel", 32'(sel), 32'(rtt_wr_sel));
                    chk_rtt("rtt_value", on ? (sel ? wv : nv) : RTT_OFF, rtt_value);
                    chk("settle", 32'(on && sel != was), 32'(rtt_settle));
                    was = sel;
                    @(posedge ck);
                end
            end
        join
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        summarize();
    end

    initial begin
        arst_n     = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 12'h000;
        pwdata     = 32'h0;
        num_errors = 0;
        cmp_count  = 0;
        lat_l      = 3;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        apb(1'b0, `LAT_OFS, 32'h0);
        chk("lat_reset", 32'h0000_0005, rd);
        apb(1'b0, `MODE2_OFS, 32'h0);
        chk("mode2_reset", 32'h0, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped_err", 32'h1, 32'(err));
        apb(1'b1, `MODE1_OFS, mr1(3'h2));
        apb(1'b1, `MODE2_OFS, mr2(2'h1));
        chk("busy_err", 32'h1, 32'(err));
        do apb(1'b0, `STAT_OFS, 32'h0); while (rd[`ST_PEND] !== 1'b0);
        apb(1'b0, `MODE2_OFS, 32'h0);
        chk("busy_ignored", 32'h0, rd);
        for (c = 0; c < 8; c++) begin
            cfg(`MODE1_OFS, mr1(3'(c)));
            apb(1'b0, `STAT_OFS, 32'h0);
            chk("nom_rsvd", 32'(c > 5), 32'(rd[`ST_NOM_RSVD]));
            run(1'b0, 1'b0, 1'b0, 4, 0, nom_of(3'(c)), RTT_OFF);
        end
        // nominal kept to an allowed value while writes run
        cfg(`MODE1_OFS, mr1(3'h2));
        for (c = 0; c < 4; c++) begin
            cfg(`MODE2_OFS, mr2(2'(c)));
            apb(1'b0, `STAT_OFS, 32'h0);
            chk("wr_rsvd", 32'(c == 3), 32'(rd[`ST_WR_RSVD]));
            run(1'b1, c != 0, c[0], 8, 0, RTT_RZQ2, wr_of(2'(c)));
        end
        cfg(`MODE2_OFS, mr2(2'h1));
        run(1'b1, 1'b1, 1'b1, 4, 0, RTT_RZQ2, RTT_RZQ4);
        run(1'b1, 1'b1, 1'b0, 6, 0, RTT_RZQ2, RTT_RZQ4);
        run(1'b1, 1'b1, 1'b0, 12, 4, RTT_RZQ2, RTT_RZQ4);
        cfg(`LAT_OFS, 32'h0000_0106);
        lat_l = 5;
        run(1'b1, 1'b1, 1'b0, 6, 0, RTT_RZQ2, RTT_RZQ4);
        summarize();
    end
endmodule
